// ### crps_pkg.sv
package crps_pkg;

  // serial management address space
  localparam logic [7:0] PAIR_ENABLE_CTRL_A_OFS = 8'h03;
  localparam logic [7:0] PAIR_ENABLE_CTRL_B_OFS = 8'h04;
  localparam logic [7:0] CLOCK_REQUEST_CONFIG_A_OFS = 8'h05;
  localparam logic [7:0] CLOCK_REQUEST_CONFIG_B_OFS = 8'h06;

  // values after reset
  localparam logic [7:0] PAIR_ENABLE_CTRL_A_RST = 8'h80;
  localparam logic [7:0] PAIR_ENABLE_CTRL_B_RST = 8'h80;
  localparam logic [7:0] CLOCK_REQUEST_CONFIG_A_RST = 8'h00;
  localparam logic [7:0] CLOCK_REQUEST_CONFIG_B_RST = 8'h00;

  // field positions
  localparam int PAIR11_ENABLE_BIT = 7;
  localparam int PAIR3_ENABLE_BIT = 7;
  localparam int REQUEST_C_ENABLE_BIT = 3;
  localparam int REQUEST_C_TARGET_BIT = 2;
  localparam int REQUEST_D_ENABLE_BIT = 1;
  localparam int REQUEST_D_TARGET_BIT = 0;
  localparam int REQUEST_G_ENABLE_BIT = 5;

  // reference pair indices
  localparam int NUM_PAIRS = 12;
  localparam int PAIR_C_DEFAULT = 0;
  localparam int PAIR_C_ALT = 2;
  localparam int PAIR_D_DEFAULT = 1;
  localparam int PAIR_D_ALT = 4;
  localparam int PAIR_3 = 3;
  localparam int PAIR_G = 9;
  localparam int PAIR_11 = 11;

  // serial bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEFAULT_DEVICE_ADDR = 7'h2A; // arbitrary value

  typedef enum logic [3:0] {
    CRPS_IDLE, CRPS_ADDR, CRPS_CMD, CRPS_WDATA, CRPS_ACK, CRPS_RDATA, CRPS_RACK
  } crps_bus_state_t;

  // one shared pin as seen from inside: level driven and its enable
  typedef struct packed {
    logic level;
    logic oe;
  } crps_pin_drive_t;

endpackage : crps_pkg

// ### crps_pin_select.sv
// Behaviour
// - pair 3 pins power up as clock outputs
// - config A bit 3 makes true pin line C
// - config A bit 2 steers line C pair 0/2
// - config A bit 1 makes comp pin line D
// - config A bit 0 steers line D pair 1/4
// - pair 11 disable floats it before request use
// - config B bit 5 makes line G for pair 9
module crps_pin_select #(
  parameter logic [6:0] DEVICE_ADDR = crps_pkg::DEFAULT_DEVICE_ADDR
) (
  input wire logic clk_sys_in, // system clock, 250 MHz
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic ce_in, // clock enable, freezes all state when low
  input wire logic smb_clk_in, // serial bus clock level
  input wire logic smb_data_in, // serial bus data level
  output logic smb_data_oe_out, // pull data low while high
  output logic smb_data_out, // data level when driven, always low
  input wire logic pair_clock_phase_in, // internal reference clock level
  input wire logic pair3_true_or_request_c_pin_in, // shared pin level
  output crps_pkg::crps_pin_drive_t pair3_true_or_request_c_pin_out, // shared pin drive
  input wire logic pair3_comp_or_request_d_pin_in, // shared pin level
  output crps_pkg::crps_pin_drive_t pair3_comp_or_request_d_pin_out, // shared pin drive
  input wire logic pair11_comp_or_request_g_pin_in, // shared pin level
  output crps_pkg::crps_pin_drive_t pair11_comp_or_request_g_pin_out, // shared pin drive
  output logic [crps_pkg::NUM_PAIRS-1:0] pair_run_out, // per pair clock gate
  output logic [7:0] pair_enable_ctrl_a_out, // register mirror
  output logic [7:0] pair_enable_ctrl_b_out, // register mirror
  output logic [7:0] clock_request_config_a_out, // register mirror
  output logic [7:0] clock_request_config_b_out // register mirror
);

  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  crps_pkg::crps_bus_state_t st_r;
  crps_pkg::crps_bus_state_t after_ack_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] rd_shift_r;
  logic [7:0] ptr_r;
  logic nack_r;
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] req_a_r;
  logic [7:0] req_b_r;
  logic wr_en;
  logic [7:0] rd_byte;
  logic req_c_en;
  logic req_d_en;
  logic req_g_en;
  logic pair3_on;
  logic pair11_on;
  logic [crps_pkg::NUM_PAIRS-1:0] stop_req;

  // bus inputs are synchronous; one stage of history gives edges and framing
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (ce_in) begin
      scl_q_r <= smb_clk_in;
      sda_q_r <= smb_data_in;
    end
  end

  assign scl_rise = smb_clk_in & ~scl_q_r;
  assign scl_fall = ~smb_clk_in & scl_q_r;
  assign bus_start = smb_clk_in & scl_q_r & sda_q_r & ~smb_data_in;
  assign bus_stop = smb_clk_in & scl_q_r & ~sda_q_r & smb_data_in;

  always_comb begin
    unique case (ptr_r)
      crps_pkg::PAIR_ENABLE_CTRL_A_OFS: rd_byte = ctrl_a_r;
      crps_pkg::PAIR_ENABLE_CTRL_B_OFS: rd_byte = ctrl_b_r;
      crps_pkg::CLOCK_REQUEST_CONFIG_A_OFS: rd_byte = req_a_r;
      crps_pkg::CLOCK_REQUEST_CONFIG_B_OFS: rd_byte = req_b_r;
      default: rd_byte = 8'h00;
    endcase
  end

  assign wr_en = ce_in && scl_fall && st_r == crps_pkg::CRPS_WDATA
                 && bit_cnt_r == crps_pkg::BITS_PER_BYTE;

  // serial bus slave: byte writes with auto-increment, reads from the pointer
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st_r <= crps_pkg::CRPS_IDLE;
      after_ack_r <= crps_pkg::CRPS_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rd_shift_r <= 8'h00;
      ptr_r <= 8'h00;
      nack_r <= 1'b0;
      smb_data_oe_out <= 1'b0;
    end else if (ce_in) begin
      if (bus_stop) begin
        st_r <= crps_pkg::CRPS_IDLE;
        smb_data_oe_out <= 1'b0;
      end else if (bus_start) begin
        st_r <= crps_pkg::CRPS_ADDR;
        bit_cnt_r <= 4'h0;
        smb_data_oe_out <= 1'b0;
      end else if (scl_rise) begin
        unique case (st_r)
          crps_pkg::CRPS_ADDR, crps_pkg::CRPS_CMD, crps_pkg::CRPS_WDATA: begin
            shift_r <= {shift_r[6:0], smb_data_in};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          crps_pkg::CRPS_RDATA: bit_cnt_r <= bit_cnt_r + 4'h1;
          crps_pkg::CRPS_RACK: nack_r <= smb_data_in;
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (st_r)
          crps_pkg::CRPS_ADDR: begin
            if (bit_cnt_r == crps_pkg::BITS_PER_BYTE) begin
              if (shift_r[7:1] == DEVICE_ADDR) begin
                smb_data_oe_out <= 1'b1;
                st_r <= crps_pkg::CRPS_ACK;
                after_ack_r <= shift_r[0] ? crps_pkg::CRPS_RDATA : crps_pkg::CRPS_CMD;
              end else begin
                st_r <= crps_pkg::CRPS_IDLE;
              end
            end
          end
          crps_pkg::CRPS_CMD: begin
            if (bit_cnt_r == crps_pkg::BITS_PER_BYTE) begin
              ptr_r <= shift_r;
              smb_data_oe_out <= 1'b1;
              st_r <= crps_pkg::CRPS_ACK;
              after_ack_r <= crps_pkg::CRPS_WDATA;
            end
          end
          crps_pkg::CRPS_WDATA: begin
            if (bit_cnt_r == crps_pkg::BITS_PER_BYTE) begin
              ptr_r <= ptr_r + 8'h01;
              smb_data_oe_out <= 1'b1;
              st_r <= crps_pkg::CRPS_ACK;
              after_ack_r <= crps_pkg::CRPS_WDATA;
            end
          end
          crps_pkg::CRPS_ACK: begin
            bit_cnt_r <= 4'h0;
            st_r <= after_ack_r;
            if (after_ack_r == crps_pkg::CRPS_RDATA) begin
              rd_shift_r <= rd_byte;
              smb_data_oe_out <= ~rd_byte[7];
            end else begin
              smb_data_oe_out <= 1'b0;
            end
          end
          crps_pkg::CRPS_RDATA: begin
            if (bit_cnt_r == crps_pkg::BITS_PER_BYTE) begin
              smb_data_oe_out <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
              st_r <= crps_pkg::CRPS_RACK;
            end else begin
              rd_shift_r <= {rd_shift_r[6:0], 1'b0};
              smb_data_oe_out <= ~rd_shift_r[6];
            end
          end
          crps_pkg::CRPS_RACK: begin
            // a master nack ends the read; the stop or a new start follows
            if (nack_r) begin
              st_r <= crps_pkg::CRPS_IDLE;
            end else begin
              bit_cnt_r <= 4'h0;
              rd_shift_r <= rd_byte;
              smb_data_oe_out <= ~rd_byte[7];
              st_r <= crps_pkg::CRPS_RDATA;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // pin roles live only in these bytes, so only bus writes and reset move them
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ctrl_a_r <= crps_pkg::PAIR_ENABLE_CTRL_A_RST;
      ctrl_b_r <= crps_pkg::PAIR_ENABLE_CTRL_B_RST;
      req_a_r <= crps_pkg::CLOCK_REQUEST_CONFIG_A_RST;
      req_b_r <= crps_pkg::CLOCK_REQUEST_CONFIG_B_RST;
    end else if (wr_en) begin
      unique case (ptr_r)
        crps_pkg::PAIR_ENABLE_CTRL_A_OFS: ctrl_a_r <= shift_r;
        crps_pkg::PAIR_ENABLE_CTRL_B_OFS: ctrl_b_r <= shift_r;
        crps_pkg::CLOCK_REQUEST_CONFIG_A_OFS: req_a_r <= shift_r;
        crps_pkg::CLOCK_REQUEST_CONFIG_B_OFS: req_b_r <= shift_r;
        default: ;
      endcase
    end
  end

  assign req_c_en = req_a_r[crps_pkg::REQUEST_C_ENABLE_BIT];
  assign req_d_en = req_a_r[crps_pkg::REQUEST_D_ENABLE_BIT];
  assign req_g_en = req_b_r[crps_pkg::REQUEST_G_ENABLE_BIT];
  assign pair3_on = ctrl_b_r[crps_pkg::PAIR3_ENABLE_BIT];
  assign pair11_on = ctrl_a_r[crps_pkg::PAIR11_ENABLE_BIT];

  // a pin turned to request is released even if the host skipped the disable
  // step; the disable bit alone floats the pair, which keeps contention off
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pair3_true_or_request_c_pin_out <= '{level: 1'b0, oe: 1'b0};
      pair3_comp_or_request_d_pin_out <= '{level: 1'b0, oe: 1'b0};
      pair11_comp_or_request_g_pin_out <= '{level: 1'b0, oe: 1'b0};
    end else if (ce_in) begin
      pair3_true_or_request_c_pin_out <= '{level: pair_clock_phase_in,
                                          oe: pair3_on & ~req_c_en};
      pair3_comp_or_request_d_pin_out <= '{level: ~pair_clock_phase_in,
                                          oe: pair3_on & ~req_d_en};
      pair11_comp_or_request_g_pin_out <= '{level: ~pair_clock_phase_in,
                                           oe: pair11_on & ~req_g_en};
    end
  end

  // active-high requests: a high level on an enabled line stops its pair
  always_comb begin
    stop_req = '0;
    if (req_c_en && pair3_true_or_request_c_pin_in) begin
      if (req_a_r[crps_pkg::REQUEST_C_TARGET_BIT]) begin
        stop_req[crps_pkg::PAIR_C_ALT] = 1'b1;
      end else begin
        stop_req[crps_pkg::PAIR_C_DEFAULT] = 1'b1;
      end
    end
    if (req_d_en && pair3_comp_or_request_d_pin_in) begin
      if (req_a_r[crps_pkg::REQUEST_D_TARGET_BIT]) begin
        stop_req[crps_pkg::PAIR_D_ALT] = 1'b1;
      end else begin
        stop_req[crps_pkg::PAIR_D_DEFAULT] = 1'b1;
      end
    end
    if (req_g_en && pair11_comp_or_request_g_pin_in) begin
      stop_req[crps_pkg::PAIR_G] = 1'b1;
    end
    stop_req[crps_pkg::PAIR_3] = ~pair3_on;
    stop_req[crps_pkg::PAIR_11] = ~pair11_on;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pair_run_out <= '1;
      pair_enable_ctrl_a_out <= crps_pkg::PAIR_ENABLE_CTRL_A_RST;
      pair_enable_ctrl_b_out <= crps_pkg::PAIR_ENABLE_CTRL_B_RST;
      clock_request_config_a_out <= crps_pkg::CLOCK_REQUEST_CONFIG_A_RST;
      clock_request_config_b_out <= crps_pkg::CLOCK_REQUEST_CONFIG_B_RST;
    end else if (ce_in) begin
      pair_run_out <= ~stop_req;
      pair_enable_ctrl_a_out <= ctrl_a_r;
      pair_enable_ctrl_b_out <= ctrl_b_r;
      clock_request_config_a_out <= req_a_r;
      clock_request_config_b_out <= req_b_r;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    smb_data_out <= 1'b0;
  end

endmodule // crps_pin_select

// ### crps_sva.sv
module crps_sva (
  input wire logic clk_sys_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic ce_in, // enable
  input wire logic smb_clk_in, // scl
  input wire logic smb_data_in, // sda
  input wire logic smb_data_oe_out, // sda pull
  input wire logic smb_data_out, // sda level
  input wire logic pair_clock_phase_in, // phase
  input wire logic pair3_true_or_request_c_pin_in, // pin c
  input crps_pkg::crps_pin_drive_t pair3_true_or_request_c_pin_out, // pin c drive
  input wire logic pair3_comp_or_request_d_pin_in, // pin d
  input crps_pkg::crps_pin_drive_t pair3_comp_or_request_d_pin_out, // pin d drive
  input wire logic pair11_comp_or_request_g_pin_in, // pin g
  input crps_pkg::crps_pin_drive_t pair11_comp_or_request_g_pin_out, // pin g drive
  input wire logic [crps_pkg::NUM_PAIRS-1:0] pair_run_out, // gates
  input wire logic [7:0] pair_enable_ctrl_a_out, // 03
  input wire logic [7:0] pair_enable_ctrl_b_out, // 04
  input wire logic [7:0] clock_request_config_a_out, // 05
  input wire logic [7:0] clock_request_config_b_out // 06
);
  wire logic [7:0] ca = clock_request_config_a_out;
  wire logic [7:0] eb = pair_enable_ctrl_b_out;
  wire logic [11:0] run = pair_run_out;
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  property p_rst;
    $rose(rst_n_in) |-> {pair_enable_ctrl_a_out, eb, ca} == 24'h808000 && &run;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_oe_cd;
    $past(rst_n_in) |-> pair3_true_or_request_c_pin_out.oe == (eb[7] & ~ca[3])
      && pair3_comp_or_request_d_pin_out.oe == (eb[7] & ~ca[1]);
  endproperty
  a_oe_cd: assert property (p_oe_cd) else $error("pin c/d drive wrong");
  property p_oe_g;
    $past(rst_n_in) |-> pair11_comp_or_request_g_pin_out.oe
      == (pair_enable_ctrl_a_out[7] & ~clock_request_config_b_out[5]);
  endproperty
  a_oe_g: assert property (p_oe_g) else $error("pin g drive wrong");
  property p_run_en;
    $past(rst_n_in) |-> run[3] == eb[7] && run[11] == pair_enable_ctrl_a_out[7];
  endproperty
  a_run_en: assert property (p_run_en) else $error("pair 3/11 gate wrong");
  property p_req_c;
    $past(rst_n_in) && $past(ce_in) |-> run[0] == ~(ca[3] & ~ca[2]
      & $past(pair3_true_or_request_c_pin_in)) && run[2] == ~(ca[3] & ca[2]
      & $past(pair3_true_or_request_c_pin_in));
  endproperty
  a_req_c: assert property (p_req_c) else $error("line c gating wrong");
  property p_req_d;
    $past(rst_n_in) && $past(ce_in) |-> run[1] == ~(ca[1] & ~ca[0]
      & $past(pair3_comp_or_request_d_pin_in)) && run[4] == ~(ca[1] & ca[0]
      & $past(pair3_comp_or_request_d_pin_in));
  endproperty
  a_req_d: assert property (p_req_d) else $error("line d gating wrong");
  property p_req_g;
    $past(rst_n_in) && $past(ce_in) |-> run[9] == ~(clock_request_config_b_out[5]
      & $past(pair11_comp_or_request_g_pin_in));
  endproperty
  a_req_g: assert property (p_req_g) else $error("line g gating wrong");
  property p_ack;
    $rose(smb_data_oe_out) |-> !$past(smb_clk_in) && !smb_clk_in;
  endproperty
  a_ack: assert property (p_ack) else $error("data pulled with clock high");
  property p_level;
    $past(rst_n_in) && $past(ce_in) |-> !smb_data_out
      && pair3_true_or_request_c_pin_out.level == $past(pair_clock_phase_in)
      && pair3_comp_or_request_d_pin_out.level == !$past(pair_clock_phase_in)
      && pair11_comp_or_request_g_pin_out.level == !$past(pair_clock_phase_in);
  endproperty
  a_level: assert property (p_level) else $error("pin levels wrong");
  c_stop_c: cover property (ca[3] && !run[0]);
  c_stop_g: cover property (clock_request_config_b_out[5] && !run[9]);
  c_ack: cover property ($rose(smb_data_oe_out));
endmodule // crps_sva
bind crps_pin_select crps_sva u_sva (.*);

// ### crps_host.sv
module crps_host (
  input wire logic clk_in, // bench clock
  input wire logic oe_in, // device pulls data low
  output logic scl_out, // serial clock
  output logic sda_out // resolved data wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_h = 1'b1;
  // open drain with pull-up: released wire reads high
  assign sda_out = sda_h & ~oe_in;
  initial scl_out = 1'b1;
  task automatic w2();
    repeat (2) @(negedge clk_in);
  endtask
  task automatic bit_x(input logic b, output logic s);
    sda_h = b;
    w2();
    scl_out = 1'b1;
    w2();
    s = sda_out;
    scl_out = 1'b0;
    w2();
  endtask
  // ninth bit released for writes, host nack for reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, ack);
    ack = ~ack;
  endtask
  task automatic start();
    sda_h = 1'b1;
    w2();
    scl_out = 1'b1;
    w2();
    sda_h = 1'b0;
    w2();
    scl_out = 1'b0;
    w2();
  endtask
  task automatic stop();
    sda_h = 1'b0;
    w2();
    scl_out = 1'b1;
    w2();
    sda_h = 1'b1;
    w2();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] o, d, output logic ok);
    logic [7:0] q;
    logic k1, k2, k3;
    start();
    xfer({a, 1'b0}, q, k1);
    xfer(o, q, k2);
    xfer(d, q, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] q);
    logic [7:0] x;
    logic k;
    start();
    xfer({a, 1'b0}, x, k);
    xfer(o, x, k);
    start();
    xfer({a, 1'b1}, x, k);
    xfer(8'hFF, q, k);
    stop();
  endtask
endmodule // crps_host

// ### tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] A = crps_pkg::DEFAULT_DEVICE_ADDR;
  // offset, value, request pin, governed pair
  localparam logic [23:0] TBL [5] = '{24'h050800, 24'h050C02, 24'h050211,
    24'h050314, 24'h062029};
  logic clk, rst_n = 1'b0, ph = 1'b0, ce = 1'b1, scl, sda, oe;
  logic [2:0] rq = 3'b000;
  logic [11:0] run;
  logic [7:0] ea, eb, ca, cb;
  crps_pkg::crps_pin_drive_t pc, pd, pg;
  wire logic ic = pc.oe ? pc.level : rq[0];
  wire logic id = pd.oe ? pd.level : rq[1];
  wire logic ig = pg.oe ? pg.level : rq[2];
  int n_errors = 0, n_tests = 0;
  crps_pin_select dut (.clk_sys_in(clk), .rst_n_in(rst_n), .ce_in(ce), .smb_clk_in(scl),
    .smb_data_in(sda), .smb_data_oe_out(oe), .smb_data_out(), .pair_clock_phase_in(ph),
    .pair3_true_or_request_c_pin_in(ic), .pair3_true_or_request_c_pin_out(pc),
    .pair3_comp_or_request_d_pin_in(id), .pair3_comp_or_request_d_pin_out(pd),
    .pair11_comp_or_request_g_pin_in(ig), .pair11_comp_or_request_g_pin_out(pg),
    .pair_run_out(run), .pair_enable_ctrl_a_out(ea), .pair_enable_ctrl_b_out(eb),
    .clock_request_config_a_out(ca), .clock_request_config_b_out(cb));
  crps_host host (.clk_in(clk), .oe_in(oe), .scl_out(scl), .sda_out(sda));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) ph <= ~ph;
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    results();
  end
  initial begin
    logic [7:0] q;
    logic ok;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("reset regs", {ea, eb, ca, cb}, 32'h80800000);
    chk("reset pins", {run, pc.oe, pd.oe, pg.oe}, 32'h7FFF);
    chk("pin levels", {pc.level ^ pd.level, pd.level ^ pg.level}, 2'b10);
    $display("test reset done");
    host.rd(A, 8'h04, q);
    chk("read 04", q, 8'h80);
    host.wr(A, 8'h07, 8'h5A, ok);
    chk("ack 07", ok, 1'b1);
    host.rd(A, 8'h07, q);
    chk("read 07", q, 8'h00);
    host.wr(A ^ 7'h01, 8'h05, 8'h08, ok);
    chk("foreign addr", {ok, ca}, 9'h000);
    $display("test bus done");
    host.wr(A, 8'h04, 8'h00, ok);
    host.wr(A, 8'h03, 8'h00, ok);
    repeat (2) @(negedge clk);
    chk("disabled", {run[3], run[11], pc.oe, pd.oe, pg.oe}, 5'h00);
    for (int i = 0; i < 5; i++) begin
      host.wr(A, TBL[i][23:16], TBL[i][15:8], ok);
      host.rd(A, TBL[i][23:16], q);
      chk("readback", q, TBL[i][15:8]);
      rq[TBL[i][5:4]] = 1'b1;
      repeat (3) @(negedge clk);
      chk("stopped", run, 12'h7F7 & ~(12'h001 << TBL[i][3:0]));
      rq = 3'b000;
      repeat (3) @(negedge clk);
      chk("running", run, 12'h7F7);
    end
    $display("test request done");
    // clock enable low must hold the gates even while line g asks to stop
    ce = 1'b0;
    rq[2] = 1'b1;
    repeat (3) @(negedge clk);
    chk("frozen", run, 12'h7F7);
    ce = 1'b1;
    repeat (3) @(negedge clk);
    chk("thawed", run, 12'h5F7);
    rq = 3'b000;
    $display("test enable done");
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("re-reset regs", {ea, eb, ca, cb}, 32'h80800000);
    chk("re-reset pins", {run, pc.oe, pd.oe, pg.oe}, 32'h7FFF);
    $display("test re-reset done");
    results();
  end
endmodule // tb_top
